/* hdl/aom_pkg.sv */
package aom_pkg;

  // command codes
  localparam logic [7:0] CMD_READ_MEM    = 8'hf0;
  localparam logic [7:0] CMD_READ_PAGED  = 8'hc3;
  localparam logic [7:0] CMD_READ_STATUS = 8'haa;
  localparam logic [7:0] CMD_WRITE_MEM   = 8'h0f;
  localparam logic [7:0] CMD_WRITE_STAT  = 8'h55;

  // field geometry
  localparam int unsigned   DATA_BYTES     = 128;
  localparam int unsigned   STAT_BYTES     = 8;
  localparam logic [15:0]   DATA_LAST_ADDR = 16'h007f;
  localparam logic [15:0]   STAT_LAST_ADDR = 16'h0007;
  localparam logic [4:0]    PAGE_LAST_BYTE = 5'h1f;
  localparam int unsigned   PAGE_LSB       = 5;
  localparam int unsigned   WP_BYTE        = 0;

  // reset contents: erased cells read as ones, top three status bytes fixed at zero
  localparam logic [7:0]    DATA_RESET     = 8'hff;
  localparam logic [63:0]   STAT_RESET     = 64'h000000ffffffffff;
  localparam logic [7:0]    CRC_SEED       = 8'h00;
  localparam logic [7:0]    CRC_POLY_REFL  = 8'h8c;
  localparam logic [7:0]    IDLE_BYTE      = 8'hff;
  localparam logic [2:0]    LAST_BIT       = 3'h7;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_CMD    = 4'h1,
    ST_ADRL   = 4'h3,
    ST_ADRH   = 4'h2,
    ST_DATA   = 4'h6,
    ST_CRC    = 4'h7,
    ST_WAIT   = 4'h5,
    ST_VERIFY = 4'h4,
    ST_READ   = 4'hc,
    ST_ECRC   = 4'hd,
    ST_ONES   = 4'hf
  } aom_state_t;

  // one time slot from the link layer
  typedef struct packed {
    logic valid;
    logic rd;
    logic wbit;
  } aom_slot_t;

  typedef struct packed {
    aom_state_t                     st;
    logic [7:0]                     cmd;
    logic [15:0]                    addr;
    logic [7:0]                     rx;
    logic [7:0]                     scratch;
    logic [7:0]                     crc;
    logic [7:0]                     tx;
    logic [2:0]                     cnt;
    logic [DATA_BYTES-1:0][7:0]     data;
    logic [STAT_BYTES-1:0][7:0]     stat;
  } aom_regs_t;

endpackage

/* hdl/aom_memory_functions.sv */
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] data field is four 32-byte pages
// [RULE2] write byte buffered, CRC returned before programming
// [RULE3] master programs only after checking CRC
// [RULE4] program only while programming level present
// [RULE5] separate 64-bit status field, own commands
// [RULE6] status byte zero bits write-protect pages
// [RULE7] protected pages still read normally
// [RULE8] redirection bytes are plain data only
// [RULE9] FFH means page valid, else inverse
// [RULE10] master redirects by writing inverted page number
// [RULE11] programming only clears bits, AND accumulates
// [RULE12] command byte then two address bytes
// [RULE13] exactly one byte programmed per cycle
// [RULE14] reads run to field end or reset
// [RULE15] all bits shifted LSB first
// [RULE16] low address byte before high byte
// [RULE17] CRC over command and address returned
// [RULE18] master resets on bad CRC
// [RULE19] end of field yields CRC of data
// [RULE20] ones after final CRC until reset
// [RULE21] reset before end gives no CRC
// [RULE22] master may skip final CRC
// [RULE23] CRC x8+x5+x4+1, seeded with zero
// [RULE24] commands ignored until ROM selection done
// [RULE25] reset pulse aborts, programs nothing
// [RULE26] 16-bit address selects data or status; the code picks the field from the command, the address only picks the byte
module aom_memory_functions (
  input  wire logic               clk_sys,
  input  wire logic               rst,
  input  wire logic               link_reset,
  input  wire logic               rom_done,
  input  wire aom_pkg::aom_slot_t slot_i,
  input  wire logic               prog_volt,
  output      logic               rd_bit,
  output      logic               selected,
  output      logic               prog_wait
);
  import aom_pkg::*;

  aom_regs_t r_q;
  aom_regs_t r_d;

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = {1'b0, c[7:1]} ^ (fb ? CRC_POLY_REFL : 8'h00); // see [RULE23]
  endfunction

  logic        is_stat;
  logic        is_write;
  logic        known;
  logic [15:0] last_addr;
  logic [15:0] addr_inc;
  logic        at_last;
  logic        in_range;
  logic        page_end;
  logic [7:0]  cur_byte;
  logic [7:0]  next_byte;
  logic [7:0]  crc_nx;
  logic [7:0]  byte_v;
  logic        rd_slot;
  logic        wr_slot;
  logic [1:0]  page;
  logic        wp;

  always_comb begin
    // the assembled byte feeds the command decode below, so it is formed first
    byte_v    = {slot_i.wbit, r_q.rx[7:1]}; // see [RULE15]
    is_stat   = (r_q.cmd == CMD_READ_STATUS) || (r_q.cmd == CMD_WRITE_STAT); // see [RULE5]
    is_write  = (r_q.cmd == CMD_WRITE_MEM) || (r_q.cmd == CMD_WRITE_STAT);
    known     = (byte_v == CMD_READ_MEM) || (byte_v == CMD_READ_PAGED) || (byte_v == CMD_READ_STATUS)
                || (byte_v == CMD_WRITE_MEM) || (byte_v == CMD_WRITE_STAT);
    last_addr = is_stat ? STAT_LAST_ADDR : DATA_LAST_ADDR; // see [RULE26]
    addr_inc  = r_q.addr + 16'h0001;
    at_last   = (r_q.addr == last_addr);
    in_range  = (r_q.addr <= last_addr);
    page_end  = (r_q.cmd == CMD_READ_PAGED) && (r_q.addr[4:0] == PAGE_LAST_BYTE); // see [RULE1]
    // protected pages stay readable: reads never look at the protect byte
    cur_byte  = is_stat ? r_q.stat[r_q.addr[2:0]] : r_q.data[r_q.addr[6:0]]; // see [RULE7] [RULE8]
    next_byte = is_stat ? r_q.stat[addr_inc[2:0]] : r_q.data[addr_inc[6:0]];
    rd_slot   = slot_i.valid && slot_i.rd;
    wr_slot   = slot_i.valid && !slot_i.rd;
    crc_nx    = crc_step(r_q.crc, slot_i.rd ? r_q.tx[0] : slot_i.wbit);
    page      = r_q.addr[PAGE_LSB+1:PAGE_LSB];
    wp        = !r_q.stat[WP_BYTE][page]; // see [RULE6]
  end

  always_comb begin
    r_d = r_q;
    if (link_reset) begin
      // abort anywhere: scratchpad and partial command dropped, nothing programmed
      r_d.st      = ST_IDLE; // see [RULE25] [RULE21]
      r_d.cnt     = 3'h0;
      r_d.scratch = IDLE_BYTE;
      r_d.tx      = IDLE_BYTE;
      r_d.crc     = CRC_SEED;
    end else begin
      case (r_q.st)
        ST_IDLE: begin
          if (rom_done) begin // see [RULE24]
            r_d.st  = ST_CMD;
            r_d.cnt = 3'h0;
            r_d.crc = CRC_SEED; // see [RULE23]
            r_d.tx  = IDLE_BYTE;
          end
        end
        ST_CMD, ST_ADRL, ST_ADRH, ST_DATA: begin
          if (wr_slot) begin
            r_d.rx  = byte_v;
            r_d.crc = crc_nx;
            r_d.cnt = r_q.cnt + 3'h1;
            if (r_q.cnt == LAST_BIT) begin
              case (r_q.st)
                ST_CMD: begin
                  r_d.cmd = byte_v; // see [RULE12]
                  r_d.st  = known ? ST_ADRL : ST_ONES;
                end
                ST_ADRL: begin
                  r_d.addr[7:0] = byte_v; // see [RULE16]
                  r_d.st        = ST_ADRH;
                end
                ST_ADRH: begin
                  r_d.addr[15:8] = byte_v; // see [RULE16]
                  if (is_write) begin
                    r_d.st = ST_DATA;
                  end else begin
                    r_d.st = ST_CRC;
                    r_d.tx = crc_nx; // see [RULE17]
                  end
                end
                default: begin
                  r_d.scratch = byte_v; // see [RULE2]
                  r_d.st      = ST_CRC;
                  r_d.tx      = crc_nx; // see [RULE2]
                end
              endcase
            end
          end
        end
        ST_CRC: begin
          if (rd_slot) begin
            r_d.tx  = {1'b1, r_q.tx[7:1]};
            r_d.cnt = r_q.cnt + 3'h1;
            if (r_q.cnt == LAST_BIT) begin
              if (!in_range) begin
                r_d.st = ST_ONES;
                r_d.tx = IDLE_BYTE;
              end else if (is_write) begin
                r_d.st = ST_WAIT; // see [RULE3]
                r_d.tx = IDLE_BYTE;
              end else begin
                r_d.st  = ST_READ;
                r_d.tx  = cur_byte;
                r_d.crc = CRC_SEED;
              end
            end
          end
        end
        ST_READ: begin
          if (rd_slot) begin
            r_d.tx  = {1'b1, r_q.tx[7:1]};
            r_d.crc = crc_nx;
            r_d.cnt = r_q.cnt + 3'h1;
            if (r_q.cnt == LAST_BIT) begin
              if (at_last || page_end) begin
                r_d.st = ST_ECRC; // see [RULE19]
                r_d.tx = crc_nx;
              end else begin
                r_d.addr = addr_inc; // see [RULE14]
                r_d.tx   = next_byte;
              end
            end
          end
        end
        ST_ECRC: begin
          if (rd_slot) begin
            r_d.tx  = {1'b1, r_q.tx[7:1]};
            r_d.cnt = r_q.cnt + 3'h1;
            if (r_q.cnt == LAST_BIT) begin
              if ((r_q.cmd == CMD_READ_PAGED) && !at_last) begin
                r_d.st   = ST_READ;
                r_d.addr = addr_inc;
                r_d.tx   = next_byte;
                r_d.crc  = CRC_SEED;
              end else begin
                r_d.st = ST_ONES; // see [RULE20]
              end
            end
          end
        end
        ST_WAIT: begin
          // one byte per programming level, and only while the level is seen
          if (prog_volt) begin // see [RULE4] [RULE13]
            if (is_stat) begin
              r_d.stat[r_q.addr[2:0]] = cur_byte & r_q.scratch; // see [RULE11]
            end else if (!wp) begin
              r_d.data[r_q.addr[6:0]] = cur_byte & r_q.scratch; // see [RULE11] [RULE6]
            end
            r_d.tx  = (is_stat || !wp) ? (cur_byte & r_q.scratch) : cur_byte;
            r_d.st  = ST_VERIFY;
            r_d.cnt = 3'h0;
          end
        end
        ST_VERIFY: begin
          if (rd_slot) begin
            r_d.tx  = {1'b1, r_q.tx[7:1]};
            r_d.cnt = r_q.cnt + 3'h1;
            if (r_q.cnt == LAST_BIT) begin
              if (at_last) begin
                r_d.st = ST_ONES;
              end else begin
                // next pass seeds the CRC with the new low address byte
                r_d.addr = addr_inc;
                r_d.crc  = addr_inc[7:0];
                r_d.st   = ST_DATA;
              end
            end
          end
        end
        default: begin
          r_d.tx = IDLE_BYTE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r_q.st      <= ST_IDLE;
      r_q.cmd     <= 8'h00;
      r_q.addr    <= 16'h0000;
      r_q.rx      <= 8'h00;
      r_q.scratch <= IDLE_BYTE;
      r_q.crc     <= CRC_SEED;
      r_q.tx      <= IDLE_BYTE;
      r_q.cnt     <= 3'h0;
      r_q.data    <= {DATA_BYTES{DATA_RESET}};
      r_q.stat    <= STAT_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  assign rd_bit    = r_q.tx[0];
  assign selected  = (r_q.st != ST_IDLE);
  assign prog_wait = (r_q.st == ST_WAIT);

endmodule

/* verification/aom_asserts.sv */
`timescale 1ns/1ps
module aom_asserts (
  input logic               clk_sys,
  input logic               rst,
  input logic               link_reset,
  input logic               rom_done,
  input aom_pkg::aom_slot_t slot_i,
  input logic               prog_volt,
  input logic               rd_bit,
  input logic               selected,
  input logic               prog_wait
);
  import aom_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_idle_ignore: assert property (!selected && !rom_done |=> !selected) else $error("left idle unselected");
  a_rom_select: assert property (!selected && rom_done && !link_reset |=> selected) else $error("no select");
  a_abort_idle: assert property (link_reset |=> !selected && rd_bit && !prog_wait) else $error("abort failed");
  a_idle_ones: assert property (!selected |-> rd_bit) else $error("idle answer not one");
  a_prog_hold: assert property (prog_wait && !prog_volt && !link_reset |=> prog_wait) else $error("wait lost");
  a_prog_done: assert property (prog_wait && prog_volt && !link_reset |=> !prog_wait) else $error("stuck");
  a_wait_after_crc: assert property ($rose(prog_wait) |-> $past(slot_i.valid && slot_i.rd)) else $error("early wait");
  a_wait_selected: assert property (prog_wait |-> selected) else $error("wait while idle");
  // main flows: programming, read slots while selected, abort
  c_program: cover property (prog_wait && prog_volt);
  c_read_slot: cover property (selected && slot_i.valid && slot_i.rd);
  c_abort: cover property ($fell(selected));
endmodule
bind aom_memory_functions aom_asserts u_aom_asserts (.clk_sys, .rst, .link_reset, .rom_done, .slot_i,
  .prog_volt, .rd_bit, .selected, .prog_wait);

/* verification/aom_master.sv */
`timescale 1ns/1ps
// line master: one time slot per cycle, bits sent and taken lsb first
module aom_master (
  input  logic               clk_sys,
  input  logic               rd_bit,
  output aom_pkg::aom_slot_t slot
);
  import aom_pkg::*;
  initial slot = '0;
  task automatic wr_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys) slot <= '{1'b1, 1'b0, b[i]};
    end
    @(negedge clk_sys) slot <= '0;
  endtask
  // rd_bit stands until the slot is taken, so it is read as the slot is raised
  task automatic rd_byte(output logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys) slot <= '{1'b1, 1'b1, 1'b1};
      b[i] = rd_bit;
    end
    @(negedge clk_sys) slot <= '0;
  endtask
endmodule

/* verification/aom_memory_functions_bench.sv */
`timescale 1ns/1ps
module aom_memory_functions_bench;
  import aom_pkg::*;
  logic        clk_sys = 0;
  logic        rst = 1;
  logic        link_reset = 0;
  logic        rom_done = 0;
  logic        prog_volt = 0;
  aom_slot_t   slot;
  logic        rd_bit, selected, prog_wait;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [31:0] lfsr = 32'h0628f0b5;
  logic [7:0]  mem [128];
  logic [7:0]  stat [8];
  logic [7:0]  c, g, d;
  logic [15:0] a;
  always #20 clk_sys = ~clk_sys;
  aom_memory_functions u_aom_memory_functions (.clk_sys(clk_sys), .rst(rst), .link_reset(link_reset),
    .rom_done(rom_done), .slot_i(slot), .prog_volt(prog_volt), .rd_bit(rd_bit), .selected(selected),
    .prog_wait(prog_wait));
  aom_master u_aom_master (.clk_sys(clk_sys), .rd_bit(rd_bit), .slot(slot));
  function automatic logic [7:0] crc8(logic [7:0] r, logic [7:0] b);
    for (int i = 0; i < 8; i++) r = (r[0] ^ b[i]) ? ((r >> 1) ^ 8'h8c) : (r >> 1);
    return r;
  endfunction
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // every access opens with a line reset, which also aborts whatever ran before
  task automatic start(input logic [7:0] cmd, input logic [15:0] ad);
    @(negedge clk_sys);
    link_reset = 1;
    @(negedge clk_sys);
    link_reset = 0;
    rom_done = 1;
    @(negedge clk_sys);
    rom_done = 0;
    u_aom_master.wr_byte(cmd);
    u_aom_master.wr_byte(ad[7:0]);
    u_aom_master.wr_byte(ad[15:8]);
    c = crc8(crc8(crc8(8'h00, cmd), ad[7:0]), ad[15:8]);
  endtask
  // one programming pass: data byte, its crc from seed c, the level, then the verify byte
  task automatic prog_byte(input logic [7:0] cmd, input logic [15:0] ad, input logic [7:0] v, input bit volt);
    u_aom_master.wr_byte(v);
    u_aom_master.rd_byte(g);
    chk(crc8(c, v), g);
    chk(8'h01, {7'h00, prog_wait});
    if (volt) begin
      @(negedge clk_sys);
      prog_volt = 1;
      @(negedge clk_sys);
      prog_volt = 0;
      if (cmd == CMD_WRITE_STAT) stat[ad[2:0]] &= v;
      else if (stat[0][ad[6:5]]) mem[ad[6:0]] &= v;
      u_aom_master.rd_byte(g);
      chk(cmd == CMD_WRITE_STAT ? stat[ad[2:0]] : mem[ad[6:0]], g);
      chk(8'h00, {7'h00, prog_wait});
    end
  endtask
  task automatic wr_mem(input logic [7:0] cmd, input logic [15:0] ad, input logic [7:0] v, input bit volt);
    start(cmd, ad);
    prog_byte(cmd, ad, v, volt);
  endtask
  task automatic rd_field(input logic [7:0] cmd, input logic [15:0] ad, input int last);
    start(cmd, ad);
    u_aom_master.rd_byte(g);
    chk(c, g);
    c = 8'h00;
    for (int i = ad; i <= last; i++) begin
      d = (cmd == CMD_READ_STATUS) ? stat[i] : mem[i];
      u_aom_master.rd_byte(g);
      chk(d, g);
      c = crc8(c, d);
      if (cmd == CMD_READ_PAGED && i % 32 == 31 && i != last) begin
        u_aom_master.rd_byte(g);
        chk(c, g);
        c = 8'h00;
      end
    end
    u_aom_master.rd_byte(g);
    chk(c, g);
    u_aom_master.rd_byte(g);
    chk(IDLE_BYTE, g);
  endtask
  initial begin
    #1000000;
    n_fail++;
    end_of_test();
  end
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    stat = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};
    repeat (6) @(negedge clk_sys);
    rst = 0;
    u_aom_master.wr_byte(CMD_READ_MEM);
    chk(8'h00, {7'h00, selected});
    chk(8'h01, {7'h00, rd_bit});
    rd_field(CMD_READ_MEM, 16'h007e, 127);
    for (int k = 0; k < 4; k++) begin
      d = rnd();
      a = {9'h000, k[1:0], d[4:0]};
      wr_mem(CMD_WRITE_MEM, a, rnd(), 1);
      wr_mem(CMD_WRITE_MEM, a, rnd(), 1);
    end
    wr_mem(CMD_WRITE_STAT, 16'h0000, 8'hfd, 1);
    wr_mem(CMD_WRITE_MEM, 16'h0021, 8'h00, 1);
    wr_mem(CMD_WRITE_STAT, 16'h0001, 8'hfd, 1);
    // software view of the redirection bytes: inverse names the new page, ones mean valid
    start(CMD_READ_STATUS, 16'h0001);
    u_aom_master.rd_byte(g);
    chk(c, g);
    u_aom_master.rd_byte(g);
    chk(8'h02, ~g);
    u_aom_master.rd_byte(g);
    chk(IDLE_BYTE, g);
    wr_mem(CMD_WRITE_MEM, 16'h0040, 8'h00, 0);
    // a second pass reseeds the crc with the low byte of the next address
    wr_mem(CMD_WRITE_MEM, 16'h0050, rnd(), 1);
    c = 8'h51;
    prog_byte(CMD_WRITE_MEM, 16'h0051, rnd(), 1);
    rd_field(CMD_READ_MEM, 16'h0000, 127);
    rd_field(CMD_READ_PAGED, 16'h001e, 127);
    rd_field(CMD_READ_STATUS, 16'h0000, 7);
    // an unknown command leaves only ones on the line; a start past the field returns the crc, then ones
    start(8'h33, 16'h0000);
    u_aom_master.rd_byte(g);
    chk(IDLE_BYTE, g);
    start(CMD_READ_MEM, 16'h0080);
    u_aom_master.rd_byte(g);
    chk(c, g);
    u_aom_master.rd_byte(g);
    chk(IDLE_BYTE, g);
    // a read cut by a line reset, mid field or at its end, must go quiet with no crc
    for (int k = 0; k < 2; k++) begin
      a = k ? 16'h007f : 16'h0000;
      start(CMD_READ_MEM, a);
      u_aom_master.rd_byte(g);
      chk(c, g);
      u_aom_master.rd_byte(g);
      chk(mem[a[6:0]], g);
      @(negedge clk_sys);
      link_reset = 1;
      @(negedge clk_sys);
      link_reset = 0;
      u_aom_master.rd_byte(g);
      chk(IDLE_BYTE, g);
      chk(8'h00, {7'h00, selected});
    end
    end_of_test();
  end
endmodule
